//--- control_timer_core_model.sv
/* control_timer_core_model: stand-in for the counter core; the cycle state
   steps every four clocks. Assumes the clock of the register block. */
`timescale 1ns/1ps
module control_timer_core_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // core side
  output logic o_cycle_end,
  output control_timer_pkg::cycle_state_type o_cycle_state,
  output logic o_wave_a,
  output logic o_wave_b
);
  import control_timer_pkg::*;
  logic [3:0] cnt_q;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + 4'h1;
  end
  assign o_cycle_state = cycle_state_type'(cnt_q[3:2]);
  assign o_cycle_end = (cnt_q == 4'hF);
  // a and b differ in period and phase so routing mistakes show
  assign o_wave_a = cnt_q[2];
  assign o_wave_b = ~cnt_q[3];
endmodule

//--- control_timer_ctrl_regs.sv
/*
  control_timer_ctrl_regs: control registers of the 12-bit control timer:
  sync divider and enable handshake, waveform mode, output routing, override,
  command strobes, compare write steering and event input A conditioning.
  Assumes the counter logic outside supplies the cycle state, default
  waveforms and an end-of-cycle pulse, and owns the compare/capture registers.
*/
// Design decision made here: the address-and-strobe port.
// Contract
// R1: sync divider field divides timer clock by 1, 2, 4 or 8.
// R2: enable write crosses into timer domain; rewrite only after enable ready.
// R3: enable bit writable while running; 1 runs, 0 stops.
// R4: mode field selects single, double, quad ramp or up-down slope.
// R5: out D source bit picks waveform A (0) or B (1).
// R6: out C source bit picks waveform A (0) or B (1).
// R7: fifty bit copies compare B set/clear writes into compare A.
// R8: auto update plus compare B clear high write requests end-of-cycle load.
// R9: auto update and fifty plus compare A clear high write also requests it.
// R10: override bit drives waveforms from per-state override levels.
// R11: double/quad ramp: override bits 0..3 for dead A, on A, dead B, on B.
// R12: single ramp: A uses bit1/bit0, B uses bit3/bit2.
// R13: disable-at-end stops timer at cycle end; ignored during enable sync.
// R14: capture strobes A/B capture counter once synchronised.
// R15: restart strobe restarts counter once synchronised.
// R16: immediate sync strobe loads buffers once synchronised.
// R17: end-of-cycle sync strobe loads buffers at next cycle end.
// R18: strobes ignored while a command is still synchronising.
// R19: filter config passes event after four equal samples.
// R20: async config acts on outputs directly; zero does neither.
// R21: edge bit picks falling/low (0) or rising/high (1) as active.
// R22: action bit: fault only (0) or fault and capture (1).
// R23: trigger enable lets event act as trigger for input A.
// R24: command ready high when idle, drops on strobes and auto update.
// R25: enable ready drops on enable write or disable strobe, rises when synced.
// R26: strobe bits self-clear and read zero once accepted.
`timescale 1ns/1ps
module control_timer_ctrl_regs #(
  parameter int DIV_WIDTH = 3
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // timer core
  input wire logic i_cycle_end,
  input wire control_timer_pkg::cycle_state_type i_cycle_state,
  input wire logic i_wave_a_default,
  input wire logic i_wave_b_default,
  output logic o_timer_enable,
  output logic o_sync_tick,
  output control_timer_pkg::waveform_gen_select_type o_wave_mode,
  output control_timer_pkg::timer_cmd_type o_cmd,
  output control_timer_pkg::cmp_write_type o_cmp_write,
  // waveform pins
  output logic o_wave_out_a,
  output logic o_wave_out_b,
  output logic o_out_c,
  output logic o_out_d,
  // event input A
  input wire logic i_event,
  output control_timer_pkg::event_out_type o_event
);
  import control_timer_pkg::*;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic enable_q;
  logic [1:0] sync_divider_q;
  logic [CE_UPPER_MSB:CE_UPPER_LSB] ce_upper_q;
  waveform_gen_select_type wave_mode_q;
  logic [7:0] routing_q;
  logic [3:0] wave_a_override_levels_q;
  logic [3:0] wave_b_override_levels_q;
  logic [7:0] event_ctrl_q;
  logic [4:0] cmd_pend_q;
  logic auto_req_q;
  logic en_pend_q;
  logic en_target_q;
  logic disable_pend_q;
  logic eoc_armed_q;
  logic [DIV_WIDTH-1:0] div_cnt_q;
  logic [7:0] rdata_q;
  timer_cmd_type cmd_q;
  cmp_write_type cmp_q;
  logic wave_a_q, wave_b_q, out_c_q, out_d_q;
  logic event_q, event_prev_q;
  logic command_ready_flag, enable_ready_flag;
  logic wr_ce, wr_strobe, wr_cmp_b, sync_tick, auto_hit;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [DIV_WIDTH-1:0] div_last(input logic [1:0] sel);
    div_last = DIV_WIDTH'((1 << sel) - 1); // see R1
  endfunction

  function automatic logic pick_level(input logic sel, input logic a, input logic b);
    pick_level = sel ? b : a;
  endfunction

  assign wr_ce = i_wr && (i_addr == ADDR_CLOCK_ENABLE);
  assign wr_strobe = i_wr && (i_addr == ADDR_STROBE);
  assign wr_cmp_b = i_wr && ((i_addr & CMP_BANK_MASK) == ADDR_CMP_B_SET_L);
  assign auto_hit = i_wr && routing_q[AUTO_UPD_BIT] &&
                    ((i_addr == ADDR_CMP_B_CLR_H) || // see R8
                     (i_addr == ADDR_CMP_A_CLR_H && routing_q[FIFTY_BIT])); // see R9
  assign command_ready_flag = ~|cmd_pend_q && !auto_req_q; // see R24
  assign enable_ready_flag = !en_pend_q && !disable_pend_q; // see R25

  // ---------------------------------------------------------------
  // sync divider: one tick per timer-domain sample point
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt_q <= '0;
    end else if (div_cnt_q >= div_last(sync_divider_q)) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end
  assign sync_tick = (div_cnt_q >= div_last(sync_divider_q)); // see R1

  // ---------------------------------------------------------------
  // enable handshake
  // ---------------------------------------------------------------
  // divider and upper clock bits are only accepted while stopped, enable whenever enable ready is high
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_divider_q <= '0;
      ce_upper_q <= '0;
      en_target_q <= 1'b0;
      en_pend_q <= 1'b0;
    end else if (wr_ce && enable_ready_flag) begin
      en_target_q <= i_wdata[EN_BIT]; // see R3
      en_pend_q <= 1'b1; // see R25
      if (!enable_q) begin
        sync_divider_q <= i_wdata[DIV_MSB:DIV_LSB];
        ce_upper_q <= i_wdata[CE_UPPER_MSB:CE_UPPER_LSB];
      end
    end else if (en_pend_q && sync_tick) begin
      en_pend_q <= 1'b0; // see R2
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_q <= 1'b0;
      disable_pend_q <= 1'b0;
    end else begin
      if (en_pend_q && sync_tick) begin
        enable_q <= en_target_q; // see R2
      end else if (disable_pend_q && (i_cycle_end || !enable_q)) begin
        enable_q <= 1'b0; // see R13
      end
      if (wr_strobe && i_wdata[DISABLE_AT_END_STROBE_BIT] && enable_ready_flag) begin
        disable_pend_q <= 1'b1; // see R13
      end else if (disable_pend_q && (i_cycle_end || !enable_q)) begin
        disable_pend_q <= 1'b0;
      end
    end
  end

  a_enable_ready_drop: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_ce && enable_ready_flag) |=> !enable_ready_flag ##0 (en_target_q == $past(i_wdata[EN_BIT]))) // see R25
    else $error("enable ready did not drop on enable write");
  a_enable_sync_done: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (en_pend_q && sync_tick && !disable_pend_q) |=> enable_ready_flag && (enable_q == $past(en_target_q))) // see R2
    else $error("enable not taken at the sync tick");
  a_disable_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (disable_pend_q && enable_q && !i_cycle_end) |=> !enable_ready_flag && enable_q) // see R13
    else $error("disable at end acted before the cycle end");

  // ---------------------------------------------------------------
  // mode, routing, override and event registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wave_mode_q <= SINGLE_RAMP;
      routing_q <= REG_RESET;
      wave_a_override_levels_q <= '0;
      wave_b_override_levels_q <= '0;
      event_ctrl_q <= REG_RESET;
    end else if (i_wr) begin
      unique case (i_addr)
        ADDR_WAVE_MODE: wave_mode_q <= waveform_gen_select_type'(i_wdata[1:0]); // see R4
        ADDR_ROUTING: routing_q <= i_wdata;
        ADDR_OVERRIDE: begin
          wave_a_override_levels_q <= i_wdata[3:0];
          wave_b_override_levels_q <= i_wdata[7:4];
        end
        ADDR_EVENT_A: event_ctrl_q <= i_wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // command strobes
  // ---------------------------------------------------------------
  // pending bits read back as the strobe register and clear when accepted
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_pend_q <= '0;
      auto_req_q <= 1'b0;
    end else if (command_ready_flag) begin // see R18
      if (wr_strobe) begin
        cmd_pend_q <= {i_wdata[CAP_B_BIT], i_wdata[CAP_A_BIT], i_wdata[RESTART_BIT],
                       i_wdata[SYNC_NOW_BIT], i_wdata[SYNC_EOC_BIT]}; // see R24
      end
      auto_req_q <= auto_hit; // see R8
    end else if (sync_tick) begin
      cmd_pend_q <= '0; // see R26
      auto_req_q <= 1'b0;
    end
  end

  a_cmd_ignored: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_strobe && !command_ready_flag && !sync_tick) |=> (cmd_pend_q == $past(cmd_pend_q))) // see R18
    else $error("strobe accepted while a command was synchronising");
  a_cmd_ready_drop: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (command_ready_flag && (auto_hit || (wr_strobe && |i_wdata[CAP_B_BIT:SYNC_EOC_BIT])))
      |=> !command_ready_flag ##[0:8] command_ready_flag) // see R24
    else $error("command ready did not drop on a command");

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_q <= '0;
      eoc_armed_q <= 1'b0;
    end else begin
      cmd_q.capture_b <= sync_tick && cmd_pend_q[4]; // see R14
      cmd_q.capture_a <= sync_tick && cmd_pend_q[3]; // see R14
      cmd_q.restart <= sync_tick && cmd_pend_q[2]; // see R15
      cmd_q.load_buffers <= (sync_tick && cmd_pend_q[1]) || (eoc_armed_q && i_cycle_end); // see R16
      if (sync_tick && (cmd_pend_q[0] || auto_req_q)) begin
        eoc_armed_q <= 1'b1; // see R17
      end else if (i_cycle_end) begin
        eoc_armed_q <= 1'b0;
      end
    end
  end

  a_restart_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (sync_tick && cmd_pend_q[2]) |=> o_cmd.restart ##1 !o_cmd.restart) // see R15
    else $error("restart pulse missing or too long");
  a_eoc_load: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (eoc_armed_q && i_cycle_end && !(sync_tick && (cmd_pend_q[0] || auto_req_q)))
      |=> o_cmd.load_buffers && !eoc_armed_q) // see R17
    else $error("end of cycle load not issued");

  // ---------------------------------------------------------------
  // compare write steering
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp_q <= '0;
    end else begin
      cmp_q.b_en <= wr_cmp_b;
      cmp_q.a_en <= (i_wr && ((i_addr & CMP_BANK_MASK) == ADDR_CMP_A_SET_L)) ||
                    (wr_cmp_b && routing_q[FIFTY_BIT]); // see R7
      cmp_q.sel <= i_addr[1:0];
      cmp_q.data <= i_wdata;
    end
  end

  a_fifty_copy: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_cmp_b && routing_q[FIFTY_BIT]) |=> o_cmp_write.a_en && o_cmp_write.b_en
      && (o_cmp_write.data == $past(i_wdata))) // see R7
    else $error("compare B write not mirrored into compare A");

  // ---------------------------------------------------------------
  // waveform generation with override and routing
  // ---------------------------------------------------------------
  logic wave_a_d, wave_b_d;
  always_comb begin
    wave_a_d = i_wave_a_default;
    wave_b_d = i_wave_b_default;
    if (routing_q[OVERRIDE_BIT]) begin // see R10
      if (wave_mode_q == SINGLE_RAMP) begin
        unique case (i_cycle_state)
          DEAD_TIME_A: wave_a_d = wave_a_override_levels_q[1]; // see R12
          ON_TIME_A: wave_a_d = wave_a_override_levels_q[0];
          DEAD_TIME_B: wave_b_d = wave_b_override_levels_q[3];
          ON_TIME_B: wave_b_d = wave_b_override_levels_q[2];
        endcase
      end else begin
        wave_a_d = wave_a_override_levels_q[i_cycle_state]; // see R11
        wave_b_d = wave_b_override_levels_q[i_cycle_state];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
      out_c_q <= 1'b0;
      out_d_q <= 1'b0;
    end else begin
      wave_a_q <= wave_a_d;
      wave_b_q <= wave_b_d;
      out_c_q <= pick_level(routing_q[OUT_C_SRC_BIT], wave_a_d, wave_b_d); // see R6
      out_d_q <= pick_level(routing_q[OUT_D_SRC_BIT], wave_a_d, wave_b_d); // see R5
    end
  end

  a_route_d: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    1'b1 |=> (o_out_d == ($past(routing_q[OUT_D_SRC_BIT]) ? o_wave_out_b : o_wave_out_a))) // see R5
    else $error("output D routed from the wrong waveform");
  a_route_c: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    1'b1 |=> (o_out_c == ($past(routing_q[OUT_C_SRC_BIT]) ? o_wave_out_b : o_wave_out_a))) // see R6
    else $error("output C routed from the wrong waveform");
  a_one_ramp_ovr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (routing_q[OVERRIDE_BIT] && wave_mode_q == SINGLE_RAMP && i_cycle_state == DEAD_TIME_A)
      |=> (o_wave_out_a == $past(wave_a_override_levels_q[1])) && (o_wave_out_b == $past(i_wave_b_default))) // see R12
    else $error("single ramp override level wrong");
  a_ovr_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !routing_q[OVERRIDE_BIT] |=> (o_wave_out_a == $past(i_wave_a_default))) // see R10
    else $error("override applied while disabled");

  // ---------------------------------------------------------------
  // event input A
  // ---------------------------------------------------------------
  logic ev_filtered, ev_active_raw, ev_active;
  control_timer_event_filter #(.SAMPLES(FILTER_SAMPLES)) u_filter (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_level(i_event),
    .o_level(ev_filtered)
  );

  // polarity folded in so that active is always high
  assign ev_active_raw = event_ctrl_q[EV_EDGE_BIT] ? i_event : !i_event; // see R21

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      event_q <= 1'b0;
      event_prev_q <= 1'b0;
    end else begin
      if (event_ctrl_q[EV_CFG_MSB:EV_CFG_LSB] == EV_CFG_FILTER) begin
        event_q <= event_ctrl_q[EV_EDGE_BIT] ? ev_filtered : !ev_filtered; // see R19
      end else begin
        event_q <= ev_active_raw; // see R20
      end
      event_prev_q <= event_q;
    end
  end
  assign ev_active = event_q && event_ctrl_q[EV_TRIG_BIT]; // see R23

  // async path bypasses every flop, so glitches on the pin reach the fault logic
  assign o_event.async_fault = event_ctrl_q[EV_TRIG_BIT] && ev_active_raw &&
                               (event_ctrl_q[EV_CFG_MSB:EV_CFG_LSB] == EV_CFG_ASYNC); // see R20
  assign o_event.trigger_a = ev_active && !event_prev_q; // see R23
  assign o_event.fault = ev_active; // see R22
  assign o_event.capture = ev_active && !event_prev_q && event_ctrl_q[EV_ACTION_BIT]; // see R22

  a_event_capture: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_event.capture |-> o_event.fault && event_ctrl_q[EV_ACTION_BIT] ##1 !o_event.capture) // see R22
    else $error("capture raised without fault or action bit");

  // ---------------------------------------------------------------
  // read-back
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= REG_RESET;
    end else if (i_rd) begin
      unique case (i_addr)
        ADDR_CLOCK_ENABLE: rdata_q <= {1'b0, ce_upper_q, sync_divider_q, enable_q};
        ADDR_WAVE_MODE: rdata_q <= {6'h00, wave_mode_q};
        ADDR_ROUTING: rdata_q <= routing_q & 8'hCB;
        ADDR_OVERRIDE: rdata_q <= {wave_b_override_levels_q, wave_a_override_levels_q};
        ADDR_STROBE: rdata_q <= {disable_pend_q, 2'h0, cmd_pend_q}; // see R26
        ADDR_EVENT_A: rdata_q <= event_ctrl_q & 8'hD5;
        ADDR_STATUS: rdata_q <= {6'h00, command_ready_flag, enable_ready_flag};
        default: rdata_q <= REG_RESET;
      endcase
    end else begin
      rdata_q <= REG_RESET;
    end
  end

  assign o_rdata = rdata_q;
  assign o_timer_enable = enable_q;
  assign o_sync_tick = sync_tick;
  assign o_wave_mode = wave_mode_q;
  assign o_cmd = cmd_q;
  assign o_cmp_write = cmp_q;
  assign o_wave_out_a = wave_a_q;
  assign o_wave_out_b = wave_b_q;
  assign o_out_c = out_c_q;
  assign o_out_d = out_d_q;

endmodule

//--- control_timer_ctrl_regs_tb_top.sv
/* control_timer_ctrl_regs_tb_top: directed test of the control registers.
   Assumes the core model drives the cycle inputs; the bench owns the bus. */
`timescale 1ns/1ps
module control_timer_ctrl_regs_tb_top;
  import control_timer_pkg::*;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_event = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic i_cycle_end, i_wave_a_default, i_wave_b_default, o_timer_enable, o_sync_tick;
  logic o_wave_out_a, o_wave_out_b, o_out_c, o_out_d, wa_s, wb_s;
  logic [7:0] ov = 8'hA5;
  logic [7:0] regs [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08};
  cycle_state_type i_cycle_state, st_s;
  waveform_gen_select_type o_wave_mode;
  timer_cmd_type o_cmd;
  cmp_write_type o_cmp_write;
  event_out_type o_event;
  int err_total = 0, total_checks = 0, n = 0;
  always #10 i_mclk = ~i_mclk;
  control_timer_core_model control_timer_core_model_i (.i_mclk, .i_rst_n, .o_cycle_end(i_cycle_end),
    .o_cycle_state(i_cycle_state), .o_wave_a(i_wave_a_default), .o_wave_b(i_wave_b_default));
  control_timer_ctrl_regs control_timer_ctrl_regs_i (.i_mclk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_cycle_end, .i_cycle_state, .i_wave_a_default, .i_wave_b_default, .o_timer_enable,
    .o_sync_tick, .o_wave_mode, .o_cmd, .o_cmp_write, .o_wave_out_a, .o_wave_out_b, .o_out_c, .o_out_d,
    .i_event, .o_event);
  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    chk(nm, o_rdata, exp);
  endtask
  // waits on one of several outcomes; running out counts as a mismatch
  task automatic hold_until(input int w, input int lim);
    total_checks++;
    for (int k = 0; k < lim; k++) begin
      @(negedge i_mclk);
      if ((w == 0 && o_timer_enable === 1'b1) || (w == 1 && o_cmd.restart === 1'b1)
        || (w == 2 && o_cmd.load_buffers === 1'b1) || (w == 3 && o_event.capture === 1'b1)
        || (w == 4 && o_timer_enable === 1'b0) || (w == 5 && o_cmd === 4'h7) || (w == 6 && o_sync_tick === 1'b1)) return;
    end
    err_total++;
    $display("unexpected wait %0d: expected done seen timeout", w);
    complete_run();
  endtask
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 5; k++) rd(regs[k], REG_RESET, "reset value");
    rd(ADDR_STATUS, 8'h03, "status idle");
    wr(ADDR_CLOCK_ENABLE, 8'h01);
    hold_until(0, 10);
    rd(ADDR_STATUS, 8'h03, "status enabled");
    chk("sync tick", o_sync_tick, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_WAVE_MODE, 8'(m));
      @(negedge i_mclk);
      chk("mode", {6'h00, o_wave_mode}, 8'(m));
    end
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_ROUTING, m ? 8'h40 : 8'h80);
      @(negedge i_mclk);
      wa_s = i_wave_a_default;
      wb_s = i_wave_b_default;
      @(negedge i_mclk);
      chk("out c", o_out_c, m ? wb_s : wa_s);
      chk("out d", o_out_d, m ? wa_s : wb_s);
    end
    wr(ADDR_OVERRIDE, ov);
    wr(ADDR_ROUTING, 8'h01);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_WAVE_MODE, m ? 8'h00 : 8'h01);
      repeat (16) begin
        @(negedge i_mclk);
        st_s = i_cycle_state;
        @(negedge i_mclk);
        if (m == 0) chk("wave a", o_wave_out_a, ov[st_s]);
        if (m == 0) chk("wave b", o_wave_out_b, ov[4 + st_s]);
        else if (st_s < 2) chk("wave a", o_wave_out_a, ov[st_s ^ 1]);
        else chk("wave b", o_wave_out_b, ov[4 + (st_s ^ 1)]);
      end
    end
    wr(ADDR_STROBE, 8'h04);
    hold_until(1, 10);
    @(negedge i_mclk);
    chk("restart pulse", {7'h00, o_cmd.restart}, 8'h00);
    rd(ADDR_STROBE, 8'h00, "strobe clear");
    rd(ADDR_STATUS, 8'h03, "cmd ready");
    wr(ADDR_ROUTING, 8'h08);
    wr(ADDR_CMP_B_SET_L, 8'h5A);
    @(negedge i_mclk);
    chk("cmp en", {4'h0, o_cmp_write.a_en, o_cmp_write.b_en, o_cmp_write.sel}, 8'h0C);
    chk("cmp data", o_cmp_write.data, 8'h5A);
    wr(ADDR_ROUTING, 8'h0A);
    wr(ADDR_CMP_B_CLR_H, 8'h01);
    hold_until(2, 40);
    wr(ADDR_EVENT_A, 8'h55);
    @(posedge i_mclk);
    i_event <= 1'b1;
    hold_until(3, 12);
    wr(ADDR_STROBE, 8'h80);
    hold_until(4, 40);
    wr(ADDR_CLOCK_ENABLE, 8'h06);
    rd(ADDR_CLOCK_ENABLE, 8'h06, "clock enable");
    repeat (16) @(negedge i_mclk) n += o_sync_tick;
    chk("tick count", 8'(n), 8'h02);
    hold_until(6, 9);
    wr(ADDR_STROBE, 8'h1A);
    rd(ADDR_STATUS, 8'h01, "cmd busy");
    wr(ADDR_STROBE, 8'h04);
    hold_until(5, 12);
    @(negedge i_mclk);
    chk("cmd idle", {4'h0, o_cmd}, 8'h00);
    wr(ADDR_EVENT_A, 8'h81);
    @(negedge i_mclk);
    chk("async idle", {7'h00, o_event.async_fault}, 8'h00);
    @(posedge i_mclk) i_event <= 1'b0;
    @(negedge i_mclk);
    chk("async fault", {7'h00, o_event.async_fault}, 8'h01);
    @(negedge i_mclk);
    chk("event out", {5'h00, o_event.trigger_a, o_event.fault, o_event.capture}, 8'h06);
    complete_run();
  end
endmodule

//--- control_timer_event_filter.sv
/*
  control_timer_event_filter: noise filter for the event input; the output
  follows the input only after a run of equal samples.
  Assumes the input is already synchronous to i_mclk.
*/
`timescale 1ns/1ps
module control_timer_event_filter #(
  parameter int SAMPLES = control_timer_pkg::FILTER_SAMPLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // data
  input wire logic i_level,
  output logic o_level
);
  import control_timer_pkg::*;

  logic [SAMPLES-1:0] hist_q;
  logic level_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hist_q <= '0;
    end else begin
      hist_q <= {hist_q[SAMPLES-2:0], i_level};
    end
  end

  // four equal samples in a row before the output moves
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_q <= 1'b0;
    end else if (&hist_q) begin
      level_q <= 1'b1; // see R19
    end else if (~|hist_q) begin
      level_q <= 1'b0;
    end
  end

  assign o_level = level_q;

  a_filter_stable: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_level != $past(o_level)) |-> (hist_q == {SAMPLES{$past(o_level, 1) ^ 1'b1}})
      || (&$past(hist_q)) || (~|$past(hist_q))) // see R19
    else $error("filter output moved without a run of equal samples");

endmodule

//--- control_timer_pkg.sv
/*
  control_timer_pkg: register offsets, field positions, reset values, modes and
  carrier structs for the control timer register block.
  Assumes byte-wide registers on a plain address/strobe port.
*/
package control_timer_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CLOCK_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_WAVE_MODE = 8'h01;
  localparam logic [7:0] ADDR_ROUTING = 8'h02;
  localparam logic [7:0] ADDR_OVERRIDE = 8'h03;
  localparam logic [7:0] ADDR_STROBE = 8'h04;
  localparam logic [7:0] ADDR_EVENT_A = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0E;
  localparam logic [7:0] ADDR_CMP_A_SET_L = 8'h28;
  localparam logic [7:0] ADDR_CMP_A_CLR_H = 8'h2B;
  localparam logic [7:0] ADDR_CMP_B_SET_L = 8'h2C;
  localparam logic [7:0] ADDR_CMP_B_CLR_H = 8'h2F;
  localparam logic [7:0] CMP_BANK_MASK = 8'hFC;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int EN_BIT = 0;
  localparam int DIV_LSB = 1;
  localparam int DIV_MSB = 2;
  localparam int CE_UPPER_LSB = 3;
  localparam int CE_UPPER_MSB = 6;
  localparam int OUT_D_SRC_BIT = 7;
  localparam int OUT_C_SRC_BIT = 6;
  localparam int FIFTY_BIT = 3;
  localparam int AUTO_UPD_BIT = 1;
  localparam int OVERRIDE_BIT = 0;
  localparam int DISABLE_AT_END_STROBE_BIT = 7;
  localparam int CAP_B_BIT = 4;
  localparam int CAP_A_BIT = 3;
  localparam int RESTART_BIT = 2;
  localparam int SYNC_NOW_BIT = 1;
  localparam int SYNC_EOC_BIT = 0;
  localparam int EV_CFG_LSB = 6;
  localparam int EV_CFG_MSB = 7;
  localparam int EV_EDGE_BIT = 4;
  localparam int EV_ACTION_BIT = 2;
  localparam int EV_TRIG_BIT = 0;
  localparam int ST_CMD_RDY_BIT = 1;
  localparam int ST_EN_RDY_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int FILTER_SAMPLES = 4;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SINGLE_RAMP, DOUBLE_RAMP, QUAD_RAMP, UP_DOWN_SLOPE
  } waveform_gen_select_type;

  typedef enum logic [1:0] {
    DEAD_TIME_A, ON_TIME_A, DEAD_TIME_B, ON_TIME_B
  } cycle_state_type;

  localparam logic [1:0] EV_CFG_NEITHER = 2'h0;
  localparam logic [1:0] EV_CFG_FILTER = 2'h1;
  localparam logic [1:0] EV_CFG_ASYNC = 2'h2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic a_en;
    logic b_en;
    logic [1:0] sel;
    logic [7:0] data;
  } cmp_write_type;

  typedef struct packed {
    logic restart;
    logic capture_a;
    logic capture_b;
    logic load_buffers;
  } timer_cmd_type;

  typedef struct packed {
    logic trigger_a;
    logic fault;
    logic capture;
    logic async_fault;
  } event_out_type;

endpackage
